// *** dv/iefr_event_src.sv ***
/*
  Event source model: the peripherals that pulse interrupt events.
  Assumes one-cycle fire commands from the testbench on the same clock.
*/
`timescale 1ns/100ps
module iefr_event_src
  import iefr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Command from the bench
  input wire logic fire,
  input wire logic [3:0] sel,
  // Event pulses to the block
  output iefr_events_t events
);
  // One source pulses for one cycle, all idle low otherwise
  always_ff @(posedge clock)
  begin
    if (reset)
      events <= '0;
    else
      events <= fire ? iefr_events_t'(9'h1 << sel) : '0;
  end
endmodule

// *** dv/testbench.sv ***
/*
  Testbench for the interrupt enable and flag registers.
  Assumes the event source model drives EVENTS; bench drives the rest.
*/
`timescale 1ns/100ps
module testbench
  import iefr_pkg::*;
;
  logic clock, reset, wr, rd, fire, prio, irq_h, irq_l, intr;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [3:0] pb, sel;
  iefr_ccp_mode_t mode;
  iefr_events_t ev;
  int n_mismatch, check_count;
  localparam logic [11:0] CTL = IEFR_CORE_CTRL_IDX;
  localparam logic [11:0] FL2 = IEFR_FLAGS_TWO_IDX;

  iefr_regs iefr_regs_inst (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EVENTS(ev), .CCP_MODE(mode), .PORT_B_INPUT(pb),
    .PRIORITY_MODE_ENABLE(prio), .IRQ_HIGH(irq_h), .IRQ_LOW(irq_l), .INTERRUPT(intr));
  iefr_event_src iefr_event_src_inst (.clock(clock), .reset(reset), .fire(fire),
    .sel(sel), .events(ev));

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write, one cycle strobe
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Register read, data in the next cycle only
  task rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  // Fire one event source and let it land
  task pulse(input int s);
    @(posedge clock);
    fire <= 1'b1;
    sel <= s[3:0];
    @(posedge clock);
    fire <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Request levels once settled
  task irq(input logic h, input logic l);
    repeat (3) @(posedge clock);
    #1 chk({6'h0, irq_h, irq_l}, {6'h0, h, l});
  endtask

  // Counts and verdict
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    n_mismatch++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    {reset, wr, rd, fire, prio, addr, wdata, pb, sel} = '1;
    {wr, rd, fire, prio, addr, wdata, pb, sel} = '0;
    mode = IEFR_CCP_CAPTURE;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd_chk(CTL, 8'h00);
    rd_chk(FL2, 8'h00);
    rd_chk(12'h123, 8'h00);
    // Every pulsed source sets its flag with all enables clear
    for (int i = 0; i < 9; i++)
    begin
      pulse(i);
      irq(1'b0, 1'b0);
      if (i >= 7)
        rd_chk(CTL, 8'(1 << (i - 6)));
      else
        rd_chk(FL2, 8'(1 << ((i >= 4) ? i + 1 : i)));
      wr_reg(CTL, 8'h00);
      wr_reg(FL2, 8'h00);
    end
    wr_reg(FL2, 8'hff);
    rd_chk(FL2, 8'hef);
    wr_reg(FL2, 8'h00);
    // Capture unit flag by mode
    mode <= IEFR_CCP_PWM;
    pulse(0);
    rd_chk(FL2, 8'h00);
    @(posedge clock);
    mode <= IEFR_CCP_COMPARE;
    pulse(0);
    rd_chk(FL2, 8'h01);
    wr_reg(FL2, 8'h00);
    mode <= IEFR_CCP_OFF;
    pulse(0);
    rd_chk(FL2, 8'h00);
    @(posedge clock);
    // Port change; clearing fails until a read and one instruction cycle
    pb <= 4'h5;
    repeat (6) @(posedge clock);
    wr_reg(CTL, 8'h00);
    rd_chk(CTL, 8'h01);
    repeat (6) @(posedge clock);
    wr_reg(CTL, 8'h00);
    rd_chk(CTL, 8'h00);
    // Single-level gating
    pulse(8);
    wr_reg(CTL, 8'h24);
    irq(1'b0, 1'b0);
    wr_reg(CTL, 8'ha4);
    irq(1'b1, 1'b0);
    wr_reg(CTL, 8'h84);
    irq(1'b0, 1'b0);
    pulse(6);
    irq(1'b0, 1'b0);
    wr_reg(CTL, 8'hc0);
    irq(1'b1, 1'b0);
    // Block interrupt: status, mask, clear
    rd_chk(IEFR_IRQ_STAT_IDX, 8'h01);
    chk({7'h0, intr}, 8'h00);
    wr_reg(IEFR_IRQ_MASK_IDX, 8'h01);
    irq(1'b1, 1'b0);
    chk({7'h0, intr}, 8'h01);
    wr_reg(CTL, 8'h00);
    wr_reg(FL2, 8'h00);
    wr_reg(IEFR_IRQ_STAT_IDX, 8'h03);
    irq(1'b0, 1'b0);
    chk({7'h0, intr}, 8'h00);
    // Two-level gating
    @(posedge clock);
    prio <= 1'b1;
    repeat (4) @(posedge clock);
    pulse(6);
    wr_reg(CTL, 8'hc0);
    irq(1'b0, 1'b1);
    wr_reg(CTL, 8'h80);
    irq(1'b0, 1'b0);
    wr_reg(CTL, 8'h40);
    irq(1'b0, 1'b0);
    rd_chk(IEFR_IRQ_STAT_IDX, 8'h02);
    wr_reg(IEFR_IRQ_MASK_IDX, 8'h02);
    irq(1'b0, 1'b0);
    chk({7'h0, intr}, 8'h01);
    // Peripheral flag classed high priority, then timer zero as a high priority request
    wr_reg(IEFR_PRIO_IDX, 8'hff);
    rd_chk(IEFR_PRIO_IDX, 8'hef);
    wr_reg(CTL, 8'h80);
    irq(1'b1, 1'b0);
    wr_reg(IEFR_PRIO_IDX, 8'h00);
    wr_reg(FL2, 8'h00);
    wr_reg(CTL, 8'ha0);
    pulse(8);
    irq(1'b1, 1'b0);
    wr_reg(CTL, 8'h24);
    irq(1'b0, 1'b0);
    wrap_up;
  end
endmodule

// *** rtl/iefr_pkg.sv ***
/*
  Package for the interrupt enable and flag register block: register indices,
  field positions, reset values, timing and the carrier structs.
  Assumes a single 50 MHz clock domain.
*/
package iefr_pkg;

  // Register offsets, used directly as register indices
  localparam logic [11:0] IEFR_CORE_CTRL_IDX = 12'hff2;
  localparam logic [11:0] IEFR_FLAGS_TWO_IDX = 12'hfa1;
  localparam logic [11:0] IEFR_PRIO_IDX = 12'hfa2;
  localparam logic [11:0] IEFR_IRQ_STAT_IDX = 12'hfa3;
  localparam logic [11:0] IEFR_IRQ_MASK_IDX = 12'hfa4;

  // Core control field positions
  localparam int IEFR_GHE_BIT = 7;
  localparam int IEFR_PLE_BIT = 6;
  localparam int IEFR_T0E_BIT = 5;
  localparam int IEFR_EXE_BIT = 4;
  localparam int IEFR_PCE_BIT = 3;
  localparam int IEFR_T0F_BIT = 2;
  localparam int IEFR_EGF_BIT = 1;
  localparam int IEFR_PCF_BIT = 0;

  // Second flag register field positions
  localparam int IEFR_OSC_BIT = 7;
  localparam int IEFR_CM2_BIT = 6;
  localparam int IEFR_CM1_BIT = 5;
  localparam int IEFR_RSV_BIT = 4;
  localparam int IEFR_BCL_BIT = 3;
  localparam int IEFR_VDT_BIT = 2;
  localparam int IEFR_T3F_BIT = 1;
  localparam int IEFR_CCP_BIT = 0;

  // Reset values and masks
  localparam logic [7:0] IEFR_CORE_CTRL_RST = 8'h00;
  localparam logic [7:0] IEFR_FLAGS_TWO_RST = 8'h00;
  localparam logic [7:0] IEFR_PRIO_RST = 8'h00;
  localparam logic [7:0] IEFR_FLAGS_TWO_MASK = 8'hef;
  localparam logic [1:0] IEFR_IRQ_RST = 2'h0;

  // Mismatch ends one instruction cycle (four clocks) after a control register read
  localparam int IEFR_TCY_NS = 80;
  localparam int IEFR_CLK_NS = 20;
  localparam int IEFR_TCY_CYC = (IEFR_TCY_NS + IEFR_CLK_NS - 1) / IEFR_CLK_NS;

  // Capture/compare unit two modes
  typedef enum logic [1:0] {
    IEFR_CCP_OFF = 2'b00,
    IEFR_CCP_CAPTURE = 2'b01,
    IEFR_CCP_COMPARE = 2'b10,
    IEFR_CCP_PWM = 2'b11
  } iefr_ccp_mode_t;

  // Peripheral event pulses
  typedef struct packed {
    logic timer_zero_ovf;
    logic ext_edge;
    logic osc_fail;
    logic comparator_two;
    logic comparator_one;
    logic bus_collision;
    logic voltage_detect;
    logic timer_three_ovf;
    logic capcmp_two;
  } iefr_events_t;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iefr_bus_t;

endpackage

// *** rtl/iefr_regs.sv ***
/*
  Interrupt enable and flag registers: core control, second peripheral flag
  register, priority classes, and a block status/mask interrupt.
  Assumes event pulses come from logic on CLOCK; port B pins and the priority
  mode strap come from outside and are synchronised here.
*/
// Operation
// - Flags set on their source event regardless of any enable.
// - Single-level mode: bit 7 passes unmasked requests, clear blocks all.
// - Two-level mode: bit 7 enables high priority, clear blocks all.
// - Single-level mode: bit 6 gates all peripheral requests.
// - Two-level mode with bit 7 set: bit 6 enables low priority.
// - Bits 5, 4, 3 enable timer zero, external edge, port change.
// - Timer zero overflow sets bit 2 until software clears it.
// - External edge event sets bit 1 until software clears it.
// - Any change on port B bits 7:4 sets bit 0 until cleared.
// - Ongoing mismatch keeps setting bit 0; control register read then one TCY ends it.
// - Oscillator failure sets second flag bit 7 until cleared.
// - Comparator two and one changes set bits 6 and 5.
// - Bus collision sets bit 3; bit 4 reads zero.
// - Voltage detect event sets bit 2 until cleared.
// - Timer three overflow sets bit 1 until cleared.
// - Capture or compare event sets bit 0; unused in PWM mode.
`timescale 1ns/100ps
module iefr_regs
  import iefr_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Register port
  input wire logic [11:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // Event sources, capture unit mode and priority mode strap
  input wire iefr_events_t EVENTS,
  input wire iefr_ccp_mode_t CCP_MODE,
  input wire logic [3:0] PORT_B_INPUT,
  input wire logic PRIORITY_MODE_ENABLE,
  // Requests to the core
  output logic IRQ_HIGH,
  output logic IRQ_LOW,
  output logic INTERRUPT
);

  iefr_bus_t bus;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] prio_reg, prio_next;
  logic [1:0] stat_reg, stat_next;
  logic [1:0] mask_reg, mask_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_high_reg, irq_high_next;
  logic irq_low_reg, irq_low_next;
  logic int_reg, int_next;
  logic [3:0] pb_meta_reg, pb_sync_reg, pb_latch_reg, pb_latch_next;
  logic pm_meta_reg, pm_sync_reg;
  logic [2:0] tcy_cnt_reg, tcy_cnt_next;
  logic mismatch;
  logic [7:0] ctrl_set, flags_set;
  logic [8:0] core_pend, periph_pend;
  logic hi_req, lo_req;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Two-flop synchronisers for pins and the mode strap
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      pb_meta_reg <= 4'h0;
      pb_sync_reg <= 4'h0;
      pm_meta_reg <= 1'b0;
      pm_sync_reg <= 1'b0;
    end
    else
    begin
      pb_meta_reg <= PORT_B_INPUT;
      pb_sync_reg <= pb_meta_reg;
      pm_meta_reg <= PRIORITY_MODE_ENABLE;
      pm_sync_reg <= pm_meta_reg;
    end
  end

  // Port latch is refreshed one TCY after a read of the control register
  // mismatch ends after read
  always_comb
  begin
    tcy_cnt_next = tcy_cnt_reg;
    pb_latch_next = pb_latch_reg;
    if (bus.rd && bus.addr == IEFR_CORE_CTRL_IDX)
      tcy_cnt_next = 3'(IEFR_TCY_CYC);
    else if (tcy_cnt_reg != 3'h0)
    begin
      tcy_cnt_next = tcy_cnt_reg - 3'h1;
      if (tcy_cnt_reg == 3'h1)
        pb_latch_next = pb_sync_reg;
    end
  end

  assign mismatch = (pb_sync_reg != pb_latch_reg);

  // Event set vectors
  always_comb
  begin
    ctrl_set = 8'h00;
    flags_set = 8'h00;
    ctrl_set[IEFR_T0F_BIT] = EVENTS.timer_zero_ovf;
    ctrl_set[IEFR_EGF_BIT] = EVENTS.ext_edge;
    ctrl_set[IEFR_PCF_BIT] = mismatch;
    flags_set[IEFR_OSC_BIT] = EVENTS.osc_fail;
    flags_set[IEFR_CM2_BIT] = EVENTS.comparator_two;
    flags_set[IEFR_CM1_BIT] = EVENTS.comparator_one;
    flags_set[IEFR_BCL_BIT] = EVENTS.bus_collision;
    flags_set[IEFR_VDT_BIT] = EVENTS.voltage_detect;
    flags_set[IEFR_T3F_BIT] = EVENTS.timer_three_ovf;
    flags_set[IEFR_CCP_BIT] = EVENTS.capcmp_two &&
      (CCP_MODE == IEFR_CCP_CAPTURE || CCP_MODE == IEFR_CCP_COMPARE);
  end

  // Pending sources: three core sources, seven peripheral sources
  // individual enables
  assign core_pend = {6'h00,
    ctrl_reg[IEFR_T0F_BIT] & ctrl_reg[IEFR_T0E_BIT],
    ctrl_reg[IEFR_EGF_BIT] & ctrl_reg[IEFR_EXE_BIT],
    ctrl_reg[IEFR_PCF_BIT] & ctrl_reg[IEFR_PCE_BIT]};
  assign periph_pend = {1'b0, flags_reg} & 9'h0ef;

  // Gating by the current priority mode
  // mode selects gating
  always_comb
  begin
    hi_req = 1'b0;
    lo_req = 1'b0;
    if (!pm_sync_reg)
    begin
      hi_req = ctrl_reg[IEFR_GHE_BIT] && ((|core_pend) ||
        (ctrl_reg[IEFR_PLE_BIT] && (|periph_pend)));
    end
    else
    begin
      hi_req = ctrl_reg[IEFR_GHE_BIT] && ((|core_pend) || (|(flags_reg & prio_reg)));
      lo_req = ctrl_reg[IEFR_GHE_BIT] && ctrl_reg[IEFR_PLE_BIT] &&
        (|(flags_reg & ~prio_reg));
    end
  end

  // Register updates; event set wins over software clear
  // flags independent of enables
  always_comb
  begin
    ctrl_next = ctrl_reg;
    flags_next = flags_reg;
    prio_next = prio_reg;
    mask_next = mask_reg;
    stat_next = stat_reg;
    if (bus.wr)
    begin
      case (bus.addr)
        IEFR_CORE_CTRL_IDX: ctrl_next = bus.wdata;
        IEFR_FLAGS_TWO_IDX: flags_next = bus.wdata & IEFR_FLAGS_TWO_MASK;
        IEFR_PRIO_IDX: prio_next = bus.wdata & IEFR_FLAGS_TWO_MASK;
        IEFR_IRQ_MASK_IDX: mask_next = bus.wdata[1:0];
        IEFR_IRQ_STAT_IDX: stat_next = stat_reg & ~bus.wdata[1:0];
        default: ;
      endcase
    end
    ctrl_next = ctrl_next | ctrl_set;
    flags_next = (flags_next | flags_set) & IEFR_FLAGS_TWO_MASK;
    stat_next = stat_next | {lo_req, hi_req};
  end

  // Outputs and read data
  // requests to the core
  always_comb
  begin
    irq_high_next = hi_req;
    irq_low_next = lo_req;
    int_next = |(stat_next & mask_reg);
    rdata_next = 8'h00;
    if (bus.rd)
    begin
      case (bus.addr)
        IEFR_CORE_CTRL_IDX: rdata_next = ctrl_reg;
        IEFR_FLAGS_TWO_IDX: rdata_next = flags_reg;
        IEFR_PRIO_IDX: rdata_next = prio_reg;
        IEFR_IRQ_STAT_IDX: rdata_next = {6'h00, stat_reg};
        IEFR_IRQ_MASK_IDX: rdata_next = {6'h00, mask_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // State registers
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      ctrl_reg <= IEFR_CORE_CTRL_RST;
      flags_reg <= IEFR_FLAGS_TWO_RST;
      prio_reg <= IEFR_PRIO_RST;
      stat_reg <= IEFR_IRQ_RST;
      mask_reg <= IEFR_IRQ_RST;
      rdata_reg <= 8'h00;
      irq_high_reg <= 1'b0;
      irq_low_reg <= 1'b0;
      int_reg <= 1'b0;
      tcy_cnt_reg <= 3'h0;
      pb_latch_reg <= 4'h0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      prio_reg <= prio_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      irq_high_reg <= irq_high_next;
      irq_low_reg <= irq_low_next;
      int_reg <= int_next;
      tcy_cnt_reg <= tcy_cnt_next;
      pb_latch_reg <= pb_latch_next;
    end
  end

  assign RDATA = rdata_reg;
  assign IRQ_HIGH = irq_high_reg;
  assign IRQ_LOW = irq_low_reg;
  assign INTERRUPT = int_reg;

  // Checks
  // timer zero flag sets
  t0_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.timer_zero_ovf |=> ctrl_reg[IEFR_T0F_BIT])
    else $error("timer zero flag not set");
  ext_flag_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
    ctrl_reg[IEFR_EGF_BIT] && !(bus.wr && bus.addr == IEFR_CORE_CTRL_IDX)
    |=> ctrl_reg[IEFR_EGF_BIT])
    else $error("edge flag dropped without clear");
  rsv_bit_zero_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !flags_reg[IEFR_RSV_BIT])
    else $error("reserved flag bit set");
  ccp_pwm_idle_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !flags_reg[IEFR_CCP_BIT] && CCP_MODE == IEFR_CCP_PWM && !bus.wr
    |=> !flags_reg[IEFR_CCP_BIT])
    else $error("capture flag set in PWM mode");
  global_block_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !ctrl_reg[IEFR_GHE_BIT] |=> !irq_high_reg && !irq_low_reg)
    else $error("request with global enable clear");
  periph_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !pm_sync_reg && ctrl_reg[IEFR_GHE_BIT] && ctrl_reg[IEFR_PLE_BIT] && (|flags_reg)
    |=> irq_high_reg)
    else $error("peripheral request not passed");
  low_prio_a: assert property (@(posedge CLOCK) disable iff (RESET)
    pm_sync_reg && ctrl_reg[IEFR_GHE_BIT] && ctrl_reg[IEFR_PLE_BIT] &&
    (|(flags_reg & ~prio_reg)) |=> irq_low_reg)
    else $error("low priority request missing");
  port_change_a: assert property (@(posedge CLOCK) disable iff (RESET)
    $changed(pb_sync_reg) && tcy_cnt_reg == 3'h0 |=> ctrl_reg[IEFR_PCF_BIT])
    else $error("port change flag not set");
  ext_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.ext_edge |=> ctrl_reg[IEFR_EGF_BIT])
    else $error("edge flag not set");
  osc_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.osc_fail |=> flags_reg[IEFR_OSC_BIT])
    else $error("oscillator flag not set");
  osc_flag_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
    flags_reg[IEFR_OSC_BIT] && !bus.wr |=> flags_reg[IEFR_OSC_BIT])
    else $error("oscillator flag dropped without clear");
  cmp_two_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.comparator_two |=> flags_reg[IEFR_CM2_BIT])
    else $error("comparator two flag not set");
  cmp_one_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.comparator_one |=> flags_reg[IEFR_CM1_BIT])
    else $error("comparator one flag not set");
  bcl_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.bus_collision |=> flags_reg[IEFR_BCL_BIT])
    else $error("collision flag not set");
  vdt_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.voltage_detect |=> flags_reg[IEFR_VDT_BIT])
    else $error("voltage flag not set");
  t3_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.timer_three_ovf |=> flags_reg[IEFR_T3F_BIT])
    else $error("timer three flag not set");
  ccp_flag_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    EVENTS.capcmp_two && (CCP_MODE == IEFR_CCP_CAPTURE || CCP_MODE == IEFR_CCP_COMPARE)
    |=> flags_reg[IEFR_CCP_BIT])
    else $error("capture flag not set");
  prio_rsv_zero_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !prio_reg[IEFR_RSV_BIT])
    else $error("reserved class bit set");
  port_mismatch_a: assert property (@(posedge CLOCK) disable iff (RESET)
    mismatch |=> ctrl_reg[IEFR_PCF_BIT])
    else $error("mismatch did not hold flag");
  core_pass_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !pm_sync_reg && ctrl_reg[IEFR_GHE_BIT] && (|core_pend)
    |=> irq_high_reg)
    else $error("core request not passed");
  t0_enable_a: assert property (@(posedge CLOCK) disable iff (RESET)
    ctrl_reg[IEFR_GHE_BIT] && ctrl_reg[IEFR_T0F_BIT] && ctrl_reg[IEFR_T0E_BIT]
    |=> irq_high_reg)
    else $error("timer zero request not passed");
  high_prio_a: assert property (@(posedge CLOCK) disable iff (RESET)
    pm_sync_reg && ctrl_reg[IEFR_GHE_BIT] && (|(flags_reg & prio_reg))
    |=> irq_high_reg)
    else $error("high priority request missing");
  low_block_a: assert property (@(posedge CLOCK) disable iff (RESET)
    pm_sync_reg && !ctrl_reg[IEFR_PLE_BIT] |=> !irq_low_reg)
    else $error("low request with low enable clear");
  single_no_low_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !pm_sync_reg |=> !irq_low_reg)
    else $error("low request in single-level mode");
  stat_set_a: assert property (@(posedge CLOCK) disable iff (RESET)
    hi_req |=> stat_reg[0])
    else $error("status missed a request");
  stat_sticky_a: assert property (@(posedge CLOCK) disable iff (RESET)
    stat_reg[0] && !(bus.wr && bus.addr == IEFR_IRQ_STAT_IDX)
    |=> stat_reg[0])
    else $error("status dropped without clear");
  int_level_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (|(stat_reg & mask_reg)) && !bus.wr
    |=> INTERRUPT)
    else $error("interrupt missing for masked status");
  // Read data zero when idle
  rdata_idle_a: assert property (@(posedge CLOCK) disable iff (RESET)
    !bus.rd |=> RDATA == 8'h00)
    else $error("read data without read");
  // Read data timing
  read_back_a: assert property (@(posedge CLOCK) disable iff (RESET)
    bus.rd && bus.addr == IEFR_PRIO_IDX |=> RDATA == $past(prio_reg))
    else $error("read data wrong");

endmodule
